/* pkg/lane_cfg.svh */
// Constants for the bus lane parity logic
`ifndef LANE_CFG_SVH
`define LANE_CFG_SVH
`define LANE_BYTES 4
`define LANE_BITS 8
`define ADDR_HI 30
`define ADDR_INV_LO 2
`define STATUS_IDLE 1'h1
`define STATUS_ERR 1'h0
`define SYNC_RST 3'h0
`endif

/* pkg/lane_pkg.sv */
// Types shared by the bus lane parity logic
package lane_pkg;
   // Write cycle phase
   typedef enum logic [1:0] {
      wr_idle,
      wr_first,
      wr_drive
   } wr_phase_t;
endpackage : lane_pkg

/* core/lane_parity_gen.sv */
// Per-byte even parity generator
`timescale 1ns/1ns
`include "lane_cfg.svh"
module lane_parity_gen
   import lane_pkg::*;
#(
   parameter int BYTES = `LANE_BYTES
) (
   // Data in
   input wire logic [BYTES*8-1:0] data,
   // Parity out, one bit per byte
   output logic [BYTES-1:0] parity
);
   // Even parity: bit makes the byte plus parity even
   always_comb begin
      for (int i = 0; i < BYTES; i++) begin
         parity[i] = ^data[i*`LANE_BITS +: `LANE_BITS];
      end
   end
endmodule : lane_parity_gen

/* core/pin_sync3.sv */
// Three-flop synchroniser with agreement of the last two stages
`timescale 1ns/1ns
`include "lane_cfg.svh"
module pin_sync3
   import lane_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Pin in, clean level out
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level
);
   logic [W-1:0] s1_q, s2_q, s3_q, lv_q;
   logic [W-1:0] s1_d, s2_d, s3_d, lv_d;
   // Next values: a bit changes once stages two and three agree
   always_comb begin
      s1_d = pin;
      s2_d = s1_q;
      s3_d = s2_q;
      lv_d = lv_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lv_d[i] = s3_q[i];
         end
      end
   end
   // Registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lv_q <= '0;
      end else if (ce) begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         lv_q <= lv_d;
      end
   end
   assign level = lv_q;
endmodule : pin_sync3

/* core/bus_lane_parity_logic.sv */
// Bus lane driver with write parity generation and read parity checking
// Writes: a cycle start latches address, lanes and data; the data and
// parity pins turn on one clock later and stay on until the cycle end.
// Reads: data and parity pins are taken as-is on the ready clock, and
// the status pin shows the lane check for exactly the next clock.
// Hazard: the status flop is frozen with the clock enable, so a low
// status seen while the enable drops stays low until it rises again.
`timescale 1ns/1ns
`include "lane_cfg.svh"
module bus_lane_parity_logic
   import lane_pkg::*;
#(
   parameter int AW = `ADDR_HI,
   parameter int NB = `LANE_BYTES
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Core side cycle request
   input wire logic cyc_start,
   input wire logic cyc_write,
   input wire logic [AW-1:0] cyc_addr,
   input wire logic [NB-1:0] cyc_lane_en,
   input wire logic [NB*8-1:0] cyc_wdata,
   input wire logic cyc_end,
   // Hold conditions
   input wire logic bus_hold,
   input wire logic addr_hold,
   // Ready and bus size from the ready logic, same clock
   input wire logic read_ready,
   input wire logic [NB-1:0] size_lane_en,
   // Word address lines, three-signal form
   input wire logic [AW-1:0] word_address_lines_i,
   output logic [AW-1:0] word_address_lines_o,
   output logic [AW-1:0] word_address_lines_oe,
   // Invalidation address seen on the upper lines
   output logic [AW-1:0] inval_addr,
   // Byte lane enables
   output logic [NB-1:0] byte_lane_enable_n,
   output logic [NB-1:0] byte_lane_enable_n_oe,
   // Data lines
   input wire logic [NB*8-1:0] data_lines_i,
   output logic [NB*8-1:0] data_lines_o,
   output logic data_lines_oe,
   // Parity lines
   input wire logic [NB-1:0] lane_parity_bits_i,
   output logic [NB-1:0] lane_parity_bits_o,
   output logic lane_parity_bits_oe,
   // Read data to the core, and status pin
   output logic [NB*8-1:0] rd_data,
   output logic parity_check_status_n
);
   // =====================================================
   // Address and byte enable drive
   // =====================================================
   logic [AW-1:0] addr_q, addr_d; // Latched cycle address
   logic [NB-1:0] be_q, be_d; // Latched lane enables
   logic [NB*8-1:0] wd_q, wd_d; // Latched write data
   logic [NB-1:0] wp; // Parity of write data
   wr_phase_t ph_q, ph_d; // Write phase
   logic st_q, st_d; // Parity status pin
   logic [AW-`ADDR_INV_LO-1:0] inval_hi; // Synchronised upper lines

   // Even parity bit of every byte lane, for the checks below
   function automatic logic [NB-1:0] lane_even(input logic [NB*8-1:0] w);
      lane_even = '0;
      for (int i = 0; i < NB; i++) begin
         lane_even[i] = ^w[i*`LANE_BITS +: `LANE_BITS];
      end
   endfunction : lane_even

   // Next values for cycle capture and write phase
   always_comb begin
      addr_d = addr_q;
      be_d = be_q;
      wd_d = wd_q;
      ph_d = ph_q;
      if (cyc_start) begin
         addr_d = cyc_addr;
         be_d = cyc_lane_en;
         wd_d = cyc_wdata;
      end
      case (ph_q)
         wr_idle: begin
            // First clock of a write: data not driven
            if (cyc_start && cyc_write) begin
               ph_d = wr_first;
            end
         end
         wr_first: begin
            ph_d = cyc_end ? wr_idle : wr_drive;
         end
         wr_drive: begin
            if (cyc_end) begin
               ph_d = wr_idle;
            end
         end
         default: begin
            ph_d = wr_idle;
         end
      endcase
   end

   // Upper lines in, lowest two output only: only the upper lines
   // are synchronised; the lowest two never carry an input
   pin_sync3 #(
      .W(AW - `ADDR_INV_LO)
   ) u_addr_sync (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .pin(word_address_lines_i[AW-1:`ADDR_INV_LO]),
      .level(inval_hi)
   );

   // Invalidation address: the output-only lines read as zero
   assign inval_addr = {inval_hi, {`ADDR_INV_LO{1'b0}}};

   // Write parity generator
   lane_parity_gen #(
      .BYTES(NB)
   ) u_gen (
      .data(wd_q),
      .parity(wp)
   );

   // Pin drive: address released in either hold
   always_comb begin
      // Address lines carry the latched word address
      word_address_lines_o = addr_q;
      // Both hold kinds float every word address line
      word_address_lines_oe = (bus_hold || addr_hold) ? '0 : '1;
      // Enables low for active lanes, lane i over data byte i
      byte_lane_enable_n = ~be_q;
      // Only bus hold floats the enables; address hold keeps them
      byte_lane_enable_n_oe = bus_hold ? '0 : '1;
      // Write data straight from its latch
      data_lines_o = wd_q;
      // Off in the first write clock, on from the second
      data_lines_oe = (ph_q != wr_idle) && (ph_q != wr_first);
      // Parity rides with the data, same enable
      lane_parity_bits_o = wp;
      lane_parity_bits_oe = data_lines_oe;
   end

   // =====================================================
   // Read parity check
   // =====================================================
   logic [NB*8-1:0] rd_q, rd_d; // Sampled read data
   logic [NB-1:0] miss; // Per-lane mismatch
   logic [NB-1:0] rp; // Expected parity

   // Expected parity of incoming data
   lane_parity_gen #(
      .BYTES(NB)
   ) u_chk (
      .data(data_lines_i),
      .parity(rp)
   );

   // Status for data sampled with ready, shown next clock
   always_comb begin
      // Read data kept until the next ready
      rd_d = rd_q;
      // Status inactive high on every clock without a read
      st_d = `STATUS_IDLE;
      // Odd byte plus parity on an enabled lane is a mismatch
      miss = (rp ^ lane_parity_bits_i) & be_q & size_lane_en;
      // Ready on a read: take data whatever the parity says
      if (read_ready && !cyc_write) begin
         rd_d = data_lines_i;
         st_d = (|miss) ? `STATUS_ERR : `STATUS_IDLE;
      end
   end

   // Registers, all on rising clk; the enable freezes every one of them
   // Reset: nothing latched, data pins off, status inactive high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q <= '0;
         be_q <= '0;
         wd_q <= '0;
         ph_q <= wr_idle;
         rd_q <= '0;
         st_q <= `STATUS_IDLE;
      end else if (ce) begin
         addr_q <= addr_d;
         be_q <= be_d;
         wd_q <= wd_d;
         ph_q <= ph_d;
         rd_q <= rd_d;
         st_q <= st_d;
      end
   end

   assign rd_data = rd_q;
   assign parity_check_status_n = st_q;

   // =====================================================
   // Assertions
   // =====================================================
   // Pin release in hold
   a_addr_release: assert property (
      @(posedge clk) disable iff (!rst_n)
      (bus_hold || addr_hold) |-> word_address_lines_oe == '0)
      else $error("address driven during hold");

   a_addr_drive: assert property (
      @(posedge clk) disable iff (!rst_n)
      !(bus_hold || addr_hold) |-> word_address_lines_oe == '1)
      else $error("address floated outside hold");

   a_be_release: assert property (
      @(posedge clk) disable iff (!rst_n)
      bus_hold |-> byte_lane_enable_n_oe == '0)
      else $error("byte enables driven in bus hold");

   a_be_drive: assert property (
      @(posedge clk) disable iff (!rst_n)
      !bus_hold |-> byte_lane_enable_n_oe == '1)
      else $error("byte enables floated outside bus hold");

   // Lane enables and invalidation address
   a_be_lanes: assert property (
      @(posedge clk) disable iff (!rst_n)
      ce && cyc_start |=> byte_lane_enable_n == ~$past(cyc_lane_en))
      else $error("byte enables differ from requested lanes");

   a_inval_low: assert property (
      @(posedge clk) disable iff (!rst_n)
      inval_addr[`ADDR_INV_LO-1:0] == '0)
      else $error("output-only address lines read as input");

   // Write data and parity timing
   a_first_clk: assert property (
      @(posedge clk) disable iff (!rst_n)
      ce && ph_q == wr_idle && cyc_start && cyc_write
      |=> !data_lines_oe)
      else $error("data driven in first write clock");

   a_second_clk: assert property (
      @(posedge clk) disable iff (!rst_n)
      ce && ph_q == wr_first && !cyc_end |=> data_lines_oe)
      else $error("data not driven in second write clock");

   a_data_stop: assert property (
      @(posedge clk) disable iff (!rst_n)
      ce && ph_q != wr_idle && cyc_end |=> !data_lines_oe)
      else $error("data still driven after cycle end");

   a_par_timing: assert property (
      @(posedge clk) disable iff (!rst_n)
      lane_parity_bits_oe == data_lines_oe)
      else $error("parity drive differs from data drive");

   a_par_even: assert property (
      @(posedge clk) disable iff (!rst_n)
      data_lines_oe |-> (^{data_lines_o[7:0], lane_parity_bits_o[0]}) == 0)
      else $error("lane zero parity not even");

   a_par_lanes: assert property (
      @(posedge clk) disable iff (!rst_n)
      data_lines_oe |-> lane_parity_bits_o == lane_even(data_lines_o))
      else $error("write parity not even on every lane");

   // Read capture and status
   a_rd_capture: assert property (
      @(posedge clk) disable iff (!rst_n)
      ce && read_ready && !cyc_write |=> rd_data == $past(data_lines_i))
      else $error("read data not taken on the ready clock");

   a_err_report: assert property (
      @(posedge clk) disable iff (!rst_n)
      ce && read_ready && !cyc_write && (|miss)
      |=> !parity_check_status_n)
      else $error("parity error not reported");

   a_ok_report: assert property (
      @(posedge clk) disable iff (!rst_n)
      ce && read_ready && !cyc_write
      && (((lane_even(data_lines_i) ^ lane_parity_bits_i)
      & be_q & size_lane_en) == '0)
      |=> parity_check_status_n)
      else $error("error reported on clean read lanes");

   a_idle_high: assert property (
      @(posedge clk) disable iff (!rst_n)
      ce && !(read_ready && !cyc_write) |=> parity_check_status_n)
      else $error("status low outside check clock");

   a_lane_mask: assert property (
      @(posedge clk) disable iff (!rst_n)
      ce && read_ready && ((be_q & size_lane_en) == '0)
      |=> parity_check_status_n)
      else $error("disabled lanes flagged error");
endmodule : bus_lane_parity_logic

/* test/mem_model.sv */
// Memory side model that answers reads with data and lane parity
`timescale 1ns/1ns
module mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Read request from the bench
   input wire logic go,
   input wire logic [31:0] word,
   input wire logic [3:0] bad,
   // Pins towards the device
   output logic [31:0] data,
   output logic [3:0] par,
   output logic ready
);
   // One clock of read data; a released bus flips, parity is pulled up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data <= 32'h0;
         par <= 4'hF;
         ready <= 1'b0;
      end else if (go) begin
         // All four lanes always returned
         data <= word;
         par <= {^word[31:24], ^word[23:16], ^word[15:8], ^word[7:0]} ^ bad;
         ready <= 1'b1;
      end else begin
         data <= ~data;
         par <= 4'hF;
         ready <= 1'b0;
      end
   end
endmodule : mem_model

/* test/testbench.sv */
// Bench for the bus lane parity logic
`timescale 1ns/1ns
module testbench;
   import lane_pkg::*;
   // Design pins and bench state
   logic clk, rst_n, cyc_start, cyc_write, cyc_end, bus_hold, addr_hold;
   logic ce, go, ready, d_oe, p_oe, stat_n;
   logic [29:0] cyc_addr, wa_i, wa_o, wa_oe, inval_addr, drv_addr;
   logic [3:0] cyc_lane_en, size_en, be_n, be_oe, bad, p_i, p_o, m_par;
   logic [31:0] cyc_wdata, d_i, d_o, rd_data, word, m_data;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   // Wire levels from both parties
   assign wa_i = (wa_oe & wa_o) | (~wa_oe & drv_addr);
   assign d_i = d_oe ? d_o : m_data;
   assign p_i = p_oe ? p_o : m_par;
   bus_lane_parity_logic u_bus_lane_parity_logic (.clk(clk), .rst_n(rst_n),
      .ce(ce), .cyc_start(cyc_start), .cyc_write(cyc_write),
      .cyc_addr(cyc_addr), .cyc_lane_en(cyc_lane_en), .cyc_wdata(cyc_wdata),
      .cyc_end(cyc_end), .bus_hold(bus_hold), .addr_hold(addr_hold),
      .read_ready(ready), .size_lane_en(size_en),
      .word_address_lines_i(wa_i), .word_address_lines_o(wa_o),
      .word_address_lines_oe(wa_oe), .inval_addr(inval_addr),
      .byte_lane_enable_n(be_n), .byte_lane_enable_n_oe(be_oe),
      .data_lines_i(d_i), .data_lines_o(d_o), .data_lines_oe(d_oe),
      .lane_parity_bits_i(p_i), .lane_parity_bits_o(p_o),
      .lane_parity_bits_oe(p_oe), .rd_data(rd_data),
      .parity_check_status_n(stat_n));
   mem_model u_mem_model (.clk(clk), .rst_n(rst_n), .go(go), .word(word),
      .bad(bad), .data(m_data), .par(m_par), .ready(ready));
   // Clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         final_report();
      end
   end
   // Compare and count
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s exp=%h seen=%h", nm, e, s);
      end
   endtask : chk
   // Verdict
   task final_report;
      $display("errors=%0d checks=%0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   // Write cycle with data and parity checks
   task t_write(input logic [29:0] a, input logic [3:0] l,
      input logic [31:0] d);
      cyc_start = 1'b1;
      cyc_write = 1'b1;
      cyc_addr = a;
      cyc_lane_en = l;
      cyc_wdata = d;
      @(negedge clk);
      cyc_start = 1'b0;
      chk("addr", wa_o, a);
      chk("be_n", be_n, 4'(~l));
      chk("wa_oe", wa_oe, 30'h3FFF_FFFF);
      chk("be_oe", be_oe, 4'hF);
      chk("d_oe1", d_oe, 1'b0);
      @(negedge clk);
      chk("d_oe2", d_oe, 1'b1);
      chk("d_o", d_o, d);
      chk("p_oe", p_oe, 1'b1);
      chk("p_o", p_o, {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]});
      cyc_end = 1'b1;
      @(negedge clk);
      cyc_end = 1'b0;
      cyc_write = 1'b0;
      @(negedge clk);
      chk("d_oe3", d_oe, 1'b0);
   endtask : t_write
   // Clock enable low: a write start is ignored, nothing moves
   task t_freeze;
      ce = 1'b0;
      cyc_start = 1'b1;
      cyc_write = 1'b1;
      cyc_addr = 30'h0ABC_0123;
      @(negedge clk);
      cyc_start = 1'b0;
      cyc_write = 1'b0;
      ce = 1'b1;
      chk("frz_wa", wa_o, 30'h3FFF_FFFF);
      @(negedge clk);
      chk("frz_doe", d_oe, 1'b0);
      chk("frz_wa2", wa_o, 30'h3FFF_FFFF);
   endtask : t_freeze
   // Read cycle with a chosen set of bad lanes
   task t_read(input logic [3:0] l, input logic [3:0] s, input logic [3:0] b);
      cyc_start = 1'b1;
      cyc_lane_en = l;
      size_en = s;
      @(negedge clk);
      cyc_start = 1'b0;
      word = 32'hC3A5_1E69 ^ {8{b}};
      bad = b;
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      chk("idle", stat_n, 1'b1);
      @(negedge clk);
      chk("stat", stat_n, ~|(b & l & s));
      chk("rd", rd_data, word);
      @(negedge clk);
      chk("stat_end", stat_n, 1'b1);
   endtask : t_read
   // Hold releases and invalidation address
   task t_hold;
      bus_hold = 1'b1;
      @(negedge clk);
      chk("wa_oe_bh", wa_oe, 30'h0);
      chk("be_oe_bh", be_oe, 4'h0);
      bus_hold = 1'b0;
      addr_hold = 1'b1;
      drv_addr = 30'h2BCD_5A6B;
      @(negedge clk);
      chk("wa_oe_ah", wa_oe, 30'h0);
      chk("be_oe_ah", be_oe, 4'hF);
      repeat (5) @(negedge clk);
      chk("inval", inval_addr, {drv_addr[29:2], 2'h0});
      chk("stat_h", stat_n, 1'b1);
      addr_hold = 1'b0;
   endtask : t_hold
   // Main sequence
   initial begin
      {rst_n, cyc_start, cyc_write, cyc_end, bus_hold, addr_hold, go} = '0;
      ce = 1'b1;
      cyc_addr = '0;
      cyc_lane_en = 4'h0;
      cyc_wdata = '0;
      size_en = 4'hF;
      bad = 4'h0;
      word = '0;
      drv_addr = '0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk("rst_stat", stat_n, 1'b1);
      chk("rst_be", be_n, 4'hF);
      chk("rst_doe", d_oe, 1'b0);
      t_write(30'h1234_5678, 4'h5, 32'h80FF_0137);
      t_write(30'h3FFF_FFFF, 4'hF, 32'h0102_FE7F);
      t_freeze();
      t_read(4'hF, 4'hF, 4'h0);
      t_read(4'hF, 4'hF, 4'h8);
      t_read(4'h3, 4'hF, 4'hC);
      t_read(4'hF, 4'h3, 4'h4);
      t_read(4'hF, 4'h3, 4'h1);
      t_read(4'h6, 4'hF, 4'h2);
      t_read(4'hC, 4'h3, 4'hF);
      t_hold();
      final_report();
   end
endmodule : testbench
